//--- hw/pmsm_drive_supervisor.sv
// top: drive supervisor with modes, scaling, protection, profile and pwm
// Overview of operation
// - switch sampled each cycle; low starts the motor, high stops it.
// - position code maps linearly to +/-180 degrees around 0x800.
// - speed code maps linearly to 0..2000 rpm, direction from code half.
// - bus voltage code maps linearly, 0x000 is 0 V, 0xFFF is 111 V.
// - phase current codes map linearly, -10 A to +10 A.
// - bus voltage feeds modulation and under/over-voltage trips that stop pwm.
// - each phase switch is on while command exceeds the triangle carrier.
// - compare value follows voltage command divided by bus voltage.
// - system mode has three states: stopped, driving, error.
// - stop, run and reset come from the user; faults raise error.
// - run mode advances in order only while driving.
// - alignment in init and boot; vector control only in drive.
// - hardware over-current stop releases all pwm pins at once.
// - phase currents checked every 50 us, trip above 3.82 A.
// - bus voltage checked every 50 us, trip above 28 V.
// - bus voltage checked every 50 us, trip below 14 V.
// - rotor speed checked every 50 us, trip above 3000 rpm.
// - speed measured over one full encoder channel period.
// - trapezoidal position profile from target, accel, max speed and settle wait.
`timescale 1ns/1ps
module pmsm_drive_supervisor
  import pmsm_pkg::*;
#(
  parameter int CHECK_CYCLES   = CHECK_CYCLES_DFLT,
  parameter int MIN_ENC_PERIOD = MIN_ENC_PERIOD_DFLT,
  parameter int ENC_W          = ENC_W_DFLT
)(
  input  wire logic               clk,
  input  wire logic               rstn,
  input  wire logic               start_stop_switch,
  input  wire logic               reset_event,
  input  wire logic               hw_overcurrent_n,
  input  wire logic [11:0]        command_adc_channel,
  input  wire logic [11:0]        bus_voltage_adc_channel,
  input  wire logic [11:0]        u_current_adc_channel,
  input  wire logic [11:0]        w_current_adc_channel,
  input  wire logic signed [15:0] volt_cmd_u,
  input  wire logic signed [15:0] volt_cmd_v,
  input  wire logic signed [15:0] volt_cmd_w,
  input  wire logic               enc_a,
  input  wire logic               enc_b,
  input  wire logic signed [15:0] target_angle_input,
  input  wire logic [15:0]        acceleration_time_input,
  input  wire logic [15:0]        profile_max_speed_input,
  input  wire logic [15:0]        settle_wait_input,
  output logic [2:0]              pwm_out,
  output logic [2:0]              pwm_oe,
  output sys_mode_t               system_mode,
  output run_mode_t               run_mode,
  output logic                    d_axis_align,
  output logic                    vector_control_en,
  output logic [4:0]              fault_flags,
  output logic signed [15:0]      position_cmd_ddeg,
  output logic [10:0]             speed_cmd_rpm,
  output logic                    speed_cmd_ccw,
  output logic [11:0]             bus_voltage_dv,
  output logic signed [15:0]      u_current_ma,
  output logic signed [15:0]      w_current_ma,
  output logic [ENC_W-1:0]        enc_period,
  output logic signed [31:0]      position_ref,
  output logic                    profile_done
);
  localparam logic [11:0] HALF    = 12'(CHECK_CYCLES / 2);
  localparam logic [11:0] MID_CMP = 12'(CHECK_CYCLES / 4);

  typedef struct packed {
    sys_mode_t          sys;
    run_mode_t          run;
    logic               align;
    logic               vec;
    logic [11:0]        car;
    logic               up;
    logic               tick;
    logic [15:0]        stage;
    logic [4:0]         flt;
    logic [1:0]         ph;
    logic [4:0]         bits;
    logic               busy;
    logic [27:0]        num;
    logic [12:0]        rem;
    logic               vneg;
    logic [2:0][11:0]   shd;
    logic [2:0][11:0]   cmp;
    logic [ENC_W-1:0]   eper;
    logic               eok;
    prof_t              pst;
    logic               pneg;
    logic signed [31:0] pos;
    logic [15:0]        spd;
    logic [31:0]        frac;
    logic [31:0]        adist;
    logic [15:0]        pwait;
    logic               pdone;
    logic signed [15:0] pcmd;
    logic [10:0]        scmd;
    logic               sccw;
    logic [11:0]        vdc;
    logic signed [15:0] iu;
    logic signed [15:0] iw;
  } state_t;

  state_t             q, d;
  logic signed [12:0] cmd_ofs, iu_ofs, iw_ofs;
  logic signed [13:0] iv_ofs;
  logic [11:0]        cmd_mag;
  logic               oc_hit;
  logic [4:0]         det;
  logic               pwm_en;
  logic [12:0]        den;
  logic [13:0]        dv_t;
  logic [27:0]        nnum;
  logic [11:0]        qclip;
  logic               load;
  logic [1:0]         load_ph;
  logic signed [15:0] vsel;
  logic [15:0]        vmag;
  logic signed [31:0] tgt, remd, step;
  logic [31:0]        acc_cyc, nfrac;
  logic [ENC_W-1:0]   per_a, per_b;
  logic               val_a, val_b;

  function automatic logic [13:0] mag14(input logic signed [13:0] x);
    mag14 = x[13] ? 14'(-x) : x;
  endfunction

  always_comb
  begin
    d = q;
    // triangle carrier 0..HALF..0; tick marks each valley
    d.tick = 1'b0;
    if (q.up)
    begin
      d.car = q.car + 1'b1;
      if (q.car == HALF)
      begin
        d.up  = 1'b0;
        d.car = q.car - 1'b1;
      end
    end
    else if (q.car == 12'h000)
    begin
      d.up   = 1'b1;
      d.car  = 12'h001;
      d.tick = 1'b1;
    end
    else
      d.car = q.car - 1'b1;

    // command, voltage and current scaling
    cmd_ofs = $signed({1'b0, command_adc_channel}) - $signed({1'b0, ADC_MID});
    cmd_mag = command_adc_channel[11] ? command_adc_channel - ADC_MID : ADC_MID - command_adc_channel;
    d.pcmd  = 16'((32'(cmd_ofs) * POS_FS_DDEG) >>> 11);
    d.scmd  = 11'((32'(cmd_mag) * SPD_FS_RPM) >> 11);
    d.sccw  = !command_adc_channel[11];
    d.vdc   = 12'((32'(bus_voltage_adc_channel) * VBUS_FS_DV) / ADC_FULL);
    iu_ofs  = $signed({1'b0, u_current_adc_channel}) - $signed({1'b0, ADC_MID});
    iw_ofs  = $signed({1'b0, w_current_adc_channel}) - $signed({1'b0, ADC_MID});
    iv_ofs  = -(14'(iu_ofs) + 14'(iw_ofs));
    d.iu    = 16'((32'(iu_ofs) * IFS_SPAN_MA) / ADC_FULL);
    d.iw    = 16'((32'(iw_ofs) * IFS_SPAN_MA) / ADC_FULL);

    // protection: hardware stop any cycle, the rest once per check
    oc_hit = mag14(14'(iu_ofs)) > OC_OFS || mag14(14'(iw_ofs)) > OC_OFS || mag14(iv_ofs) > OC_OFS;
    det         = 5'h00;
    det[FLT_HW] = !hw_overcurrent_n;
    if (q.tick)
    begin
      det[FLT_OC] = oc_hit;
      det[FLT_OV] = bus_voltage_adc_channel > OV_CODE;
      det[FLT_UV] = bus_voltage_adc_channel < UV_CODE;
      det[FLT_OS] = q.eok && q.eper < ENC_W'(MIN_ENC_PERIOD);
    end
    // a fault seen in the clearing cycle stays set
    if (q.sys == SYS_ERROR && reset_event)
      d.flt = det;
    else
      d.flt = q.flt | det;

    // system mode, events from the user, fault has priority
    case (q.sys)
      SYS_STOPPED:
      begin
        if (!start_stop_switch)
          d.sys = SYS_DRIVING;
      end
      SYS_DRIVING:
      begin
        if (start_stop_switch)
          d.sys = SYS_STOPPED;
      end
      SYS_ERROR:
      begin
        if (reset_event)
          d.sys = SYS_STOPPED;
      end
      default:
        d.sys = SYS_STOPPED;
    endcase
    if (|det)
      d.sys = SYS_ERROR;

    // run mode sequence, timed in checks
    if (q.sys != SYS_DRIVING)
    begin
      d.run   = RUN_IDLE;
      d.stage = 16'h0000;
    end
    else
    begin
      case (q.run)
        RUN_IDLE:
          d.run = RUN_INIT;
        RUN_INIT, RUN_BOOT:
        begin
          if (q.tick)
          begin
            d.stage = q.stage + 1'b1;
            if (q.stage == ALIGN_TICKS - 1'b1)
            begin
              d.stage = 16'h0000;
              d.run   = (q.run == RUN_INIT) ? RUN_BOOT : RUN_DRIVE;
            end
          end
        end
        RUN_DRIVE:
          d.run = RUN_DRIVE;
        default:
          d.run = RUN_IDLE;
      endcase
    end
    d.align = d.run == RUN_INIT || d.run == RUN_BOOT;
    d.vec   = d.run == RUN_DRIVE;

    // serial divide: compare offset = |v| * HALF / (2 * vbus), one phase at a time
    den     = {bus_voltage_adc_channel, 1'b0};
    dv_t    = {q.rem, q.num[27]};
    nnum    = {q.num[26:0], 1'b0};
    qclip   = 12'h000;
    load    = 1'b0;
    load_ph = 2'd0;
    if (q.tick)
      d.cmp = q.shd; // new duty only at the valley, in the middle of the on-pulse
    if (q.tick && !q.busy)
      load = 1'b1;
    if (q.busy)
    begin
      if (dv_t >= {1'b0, den})
      begin
        d.rem   = 13'(dv_t - {1'b0, den});
        nnum[0] = 1'b1;
      end
      else
        d.rem = dv_t[12:0];
      d.num  = nnum;
      d.bits = q.bits + 1'b1;
      if (q.bits == 5'd27)
      begin
        // ratio above one saturates at full duty, or at zero duty when the command is negative
        qclip = (nnum > 28'(MID_CMP)) ? MID_CMP : nnum[11:0];
        d.shd[q.ph] = q.vneg ? MID_CMP - qclip : MID_CMP + qclip;
        d.busy = 1'b0;
        if (q.ph != 2'd2)
        begin
          load    = 1'b1;
          load_ph = q.ph + 1'b1;
        end
      end
    end
    case (load_ph)
      2'd0:    vsel = volt_cmd_u;
      2'd1:    vsel = volt_cmd_v;
      default: vsel = volt_cmd_w;
    endcase
    vmag = vsel[15] ? 16'(-vsel) : vsel;
    if (load)
    begin
      d.ph   = load_ph;
      d.busy = 1'b1;
      d.bits = 5'd0;
      d.rem  = 13'h0000;
      d.vneg = vsel[15];
      d.num  = 28'(vmag) * 28'(HALF);
    end

    // latest full-period measurement from either channel
    if (val_a)
    begin
      d.eper = per_a;
      d.eok  = 1'b1;
    end
    else if (val_b)
    begin
      d.eper = per_b;
      d.eok  = 1'b1;
    end

    // trapezoidal profile in 1/256 degree, speed per check
    tgt     = {{8{target_angle_input[15]}}, target_angle_input, 8'h00};
    remd    = q.pneg ? q.pos - tgt : tgt - q.pos;
    step    = {16'h0000, q.spd};
    acc_cyc = 32'(acceleration_time_input) * 32'(CHECK_CYCLES);
    nfrac   = q.frac + 32'(profile_max_speed_input);
    if (q.run != RUN_DRIVE)
    begin
      d.pst   = PR_IDLE;
      d.pos   = 32'sh0;
      d.spd   = 16'h0000;
      d.pdone = 1'b0;
    end
    else
    begin
      case (q.pst)
        PR_IDLE, PR_DONE:
        begin
          // a new move only starts once the last move has settled
          if (tgt != q.pos && profile_max_speed_input != 16'h0000)
          begin
            d.pst   = PR_ACCEL;
            d.pneg  = tgt < q.pos;
            d.spd   = 16'h0000;
            d.frac  = 32'h0;
            d.adist = 32'h0;
            d.pdone = 1'b0;
          end
        end
        PR_ACCEL, PR_CRUISE, PR_DECEL:
        begin
          // speed ramps per clock so the slope is exact over the accel time
          if (q.pst == PR_ACCEL)
          begin
            if (q.spd >= profile_max_speed_input)
              d.pst = PR_CRUISE;
            else if (nfrac >= acc_cyc)
            begin
              d.spd  = q.spd + 1'b1;
              d.frac = nfrac - acc_cyc;
            end
            else
              d.frac = nfrac;
          end
          else if (q.pst == PR_DECEL && q.spd > 16'h0001)
          begin
            if (nfrac >= acc_cyc)
            begin
              d.spd  = q.spd - 1'b1;
              d.frac = nfrac - acc_cyc;
            end
            else
              d.frac = nfrac;
          end
          if (q.tick)
          begin
            if (remd <= step)
            begin
              d.pos   = tgt;
              d.spd   = 16'h0000;
              d.pst   = PR_SETTLE;
              d.pwait = 16'h0000;
            end
            else
            begin
              d.pos = q.pneg ? q.pos - step : q.pos + step;
              if (q.pst == PR_ACCEL)
                d.adist = q.adist + 32'(step);
              if (q.pst != PR_DECEL && remd - step <= $signed(d.adist))
              begin
                d.pst  = PR_DECEL;
                d.frac = 32'h0;
              end
            end
          end
        end
        PR_SETTLE:
        begin
          if (q.tick)
          begin
            d.pwait = q.pwait + 1'b1;
            if (q.pwait == settle_wait_input)
            begin
              d.pst   = PR_DONE;
              d.pdone = 1'b1;
            end
          end
        end
        default:
          d.pst = PR_IDLE;
      endcase
    end
  end

  // pwm pins are released the cycle after any fault is seen
  assign pwm_en = q.sys == SYS_DRIVING && q.run != RUN_IDLE && det == 5'h00;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      q <= '0;
    else
      q <= d;
  end

  for (genvar i = 0; i < 3; i++)
  begin : g_phase
    pwm_phase #(.W(12)) u_phase (
      .clk     (clk),
      .rstn    (rstn),
      .carrier (q.car),
      .compare (q.cmp[i]),
      .en      (pwm_en),
      .pwm_q   (pwm_out[i]),
      .oe_q    (pwm_oe[i])
    );
  end

  enc_period #(.W(ENC_W)) u_enc_a (
    .clk      (clk),
    .rstn     (rstn),
    .chan     (enc_a),
    .period_q (per_a),
    .valid_q  (val_a)
  );

  enc_period #(.W(ENC_W)) u_enc_b (
    .clk      (clk),
    .rstn     (rstn),
    .chan     (enc_b),
    .period_q (per_b),
    .valid_q  (val_b)
  );

  assign system_mode       = q.sys;
  assign run_mode          = q.run;
  assign d_axis_align      = q.align;
  assign vector_control_en = q.vec;
  assign fault_flags       = q.flt;
  assign position_cmd_ddeg = q.pcmd;
  assign speed_cmd_rpm     = q.scmd;
  assign speed_cmd_ccw     = q.sccw;
  assign bus_voltage_dv    = q.vdc;
  assign u_current_ma      = q.iu;
  assign w_current_ma      = q.iw;
  assign enc_period        = q.eper;
  assign position_ref      = q.pos;
  assign profile_done      = q.pdone;

  // checker helpers: cycles since the last check
  logic [15:0] gap_q;
  logic        seen_q;
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      gap_q  <= 16'h0000;
      seen_q <= 1'b0;
    end
    else
    begin
      gap_q  <= q.tick ? 16'h0000 : gap_q + 1'b1;
      seen_q <= seen_q | q.tick;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_boot_end;
    q.sys == SYS_DRIVING && q.run == RUN_BOOT && q.tick && q.stage == ALIGN_TICKS - 1'b1;
  endsequence

  a_hw_stop: assert property (!hw_overcurrent_n |=> pwm_oe == 3'b000 ##0 q.sys == SYS_ERROR)
    else $error("pins driven after hardware stop");
  a_fault_entry: assert property (det != 5'h00 |=> q.sys == SYS_ERROR && q.flt != 5'h00)
    else $error("fault did not enter error");
  a_error_hold: assert property (q.sys == SYS_ERROR && !reset_event |=> q.sys == SYS_ERROR)
    else $error("error left without reset");
  a_start_req: assert property (q.sys == SYS_STOPPED && !start_stop_switch && det == 5'h00
    |=> q.sys == SYS_DRIVING ##1 q.run == RUN_INIT || q.sys != SYS_DRIVING) else $error("start not taken");
  a_stop_req: assert property (q.sys == SYS_DRIVING && start_stop_switch && det == 5'h00
    |=> q.sys == SYS_STOPPED) else $error("stop not taken");
  a_run_gate: assert property (q.sys != SYS_DRIVING |=> q.run == RUN_IDLE && pwm_oe == 3'b000)
    else $error("run mode active outside driving");
  a_drive_entry: assert property (s_boot_end |=> q.run == RUN_DRIVE && q.vec && !q.align)
    else $error("boot did not hand over to drive");
  a_check_period: assert property (q.tick && seen_q && $past(seen_q) |-> gap_q == 16'(2 * HALF - 1))
    else $error("check spacing wrong");
  a_oc_trip: assert property (q.tick && oc_hit |=> q.flt[FLT_OC] && q.sys == SYS_ERROR)
    else $error("over-current not trapped");
  a_ov_trip: assert property (q.tick && bus_voltage_adc_channel > OV_CODE |=> q.flt[FLT_OV])
    else $error("over-voltage not trapped");
  a_uv_trip: assert property (q.tick && bus_voltage_adc_channel < UV_CODE |=> q.flt[FLT_UV])
    else $error("under-voltage not trapped");
  a_os_trip: assert property (q.tick && q.eok && q.eper < ENC_W'(MIN_ENC_PERIOD) |=> q.flt[FLT_OS])
    else $error("over-speed not trapped");
endmodule

//--- hw/pmsm_pkg.sv
// package: constants and types shared by the motor drive supervisor
package pmsm_pkg;
  localparam int CLK_HZ = 125_000_000;
  localparam int CLK_NS = 8;
  // one protection check per carrier period, at the carrier valley
  localparam int CHECK_US          = 50;
  localparam int CHECK_CYCLES_DFLT = CHECK_US * 1000 / CLK_NS;
  localparam int ADC_FULL          = 4095;
  localparam logic [11:0] ADC_MID  = 12'h800;
  // bus voltage in 0.1 V, full scale 111.0 V
  localparam int VBUS_FS_DV = 1110;
  localparam int OV_DV      = 280;
  localparam int UV_DV      = 140;
  localparam logic [11:0] OV_CODE = 12'(OV_DV * ADC_FULL / VBUS_FS_DV);
  localparam logic [11:0] UV_CODE = 12'((UV_DV * ADC_FULL + VBUS_FS_DV - 1) / VBUS_FS_DV);
  // phase current in mA, span -10 A .. +10 A
  localparam int IFS_SPAN_MA        = 20000;
  localparam int IFS_MA             = 10000;
  localparam int OC_MA              = 3820;
  localparam logic [13:0] OC_OFS    = 14'(OC_MA * 2048 / IFS_MA);
  localparam int POS_FS_DDEG        = 1800;
  localparam int SPD_FS_RPM         = 2000;
  localparam int ENC_PPR            = 300;
  localparam int SPEED_LIMIT_RPM    = 3000;
  localparam int MIN_ENC_PERIOD_DFLT = CLK_HZ / ENC_PPR * 60 / SPEED_LIMIT_RPM;
  localparam int ENC_W_DFLT         = 24;
  localparam logic [15:0] ALIGN_TICKS = 16'h07D0;
  localparam int FLT_HW = 0;
  localparam int FLT_OC = 1;
  localparam int FLT_OV = 2;
  localparam int FLT_UV = 3;
  localparam int FLT_OS = 4;
  typedef enum logic [1:0] {SYS_STOPPED, SYS_DRIVING, SYS_ERROR} sys_mode_t;
  typedef enum logic [1:0] {RUN_IDLE, RUN_INIT, RUN_BOOT, RUN_DRIVE} run_mode_t;
  typedef enum logic [2:0] {PR_IDLE, PR_ACCEL, PR_CRUISE, PR_DECEL, PR_SETTLE, PR_DONE} prof_t;
endpackage

//--- hw/pwm_phase.sv
// one phase of triangle-compare pwm with output enable
`timescale 1ns/1ps
module pwm_phase
  import pmsm_pkg::*;
#(
  parameter int W = 12
)(
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] carrier,
  input  wire logic [W-1:0] compare,
  input  wire logic         en,
  output logic              pwm_q,
  output logic              oe_q
);
  typedef struct packed {
    logic pwm;
    logic oe;
  } pwm_state_t;

  pwm_state_t q, d;

  always_comb
  begin
    d.oe  = en;
    d.pwm = en && (compare > carrier);
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      q <= '0;
    else
      q <= d;
  end

  assign pwm_q = q.pwm;
  assign oe_q  = q.oe;

  a_pwm_compare: assert property (@(posedge clk) disable iff (!rstn)
    en && compare > carrier |=> pwm_q && oe_q) else $error("switch not on while command above carrier");
  a_pwm_release: assert property (@(posedge clk) disable iff (!rstn)
    !en |=> !oe_q && !pwm_q) else $error("pin still driven while disabled");
endmodule

//--- hw/enc_period.sv
// full-period edge timer for one encoder channel
`timescale 1ns/1ps
module enc_period
  import pmsm_pkg::*;
#(
  parameter int W = 24
)(
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic         chan,
  output logic [W-1:0]      period_q,
  output logic              valid_q
);
  typedef struct packed {
    logic         prev;
    logic         arm;
    logic         sat;
    logic [W-1:0] cnt;
    logic [W-1:0] per;
    logic         val;
  } enc_state_t;

  enc_state_t q, d;
  logic       rise;

  always_comb
  begin
    d      = q;
    d.val  = 1'b0;
    d.prev = chan;
    rise   = chan && !q.prev;
    if (rise)
    begin
      // rising to rising spans both edge types, so duty error cancels
      d.cnt = '0;
      d.arm = 1'b1;
      d.sat = 1'b0;
      if (q.arm)
      begin
        d.per = (&q.cnt) ? q.cnt : q.cnt + 1'b1;
        d.val = 1'b1;
      end
    end
    else if (&q.cnt)
    begin
      // stalled shaft reports the slowest period once
      if (!q.sat && q.arm)
      begin
        d.per = q.cnt;
        d.val = 1'b1;
        d.sat = 1'b1;
      end
    end
    else
      d.cnt = q.cnt + 1'b1;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      q <= '0;
    else
      q <= d;
  end

  assign period_q = q.per;
  assign valid_q  = q.val;

  a_period_value: assert property (@(posedge clk) disable iff (!rstn)
    rise && q.arm && !(&q.cnt) |=> valid_q && period_q == $past(q.cnt) + 1'b1)
    else $error("period not one more than edge count");
endmodule

//--- bench/pmsm_encoder_model.sv
// quadrature encoder on the motor shaft, stands still when quarter is zero
`timescale 1ns/1ps
module pmsm_encoder_model (
  input  wire logic       clk,
  input  wire logic [7:0] quarter,
  output logic            enc_a,
  output logic            enc_b
);
  logic [7:0] cnt_q = 8'h00;
  logic [1:0] ph_q  = 2'h0;
  always @(posedge clk)
  begin
    if (quarter == 8'h00)
      cnt_q <= 8'h00;
    else if (cnt_q >= quarter - 8'h01)
    begin
      cnt_q <= 8'h00;
      ph_q  <= ph_q + 2'h1;
    end
    else
      cnt_q <= cnt_q + 8'h01;
  end
  // gray sequence keeps a and b in quadrature
  assign enc_a = ph_q[1];
  assign enc_b = ph_q[1] ^ ph_q[0];
endmodule

//--- bench/tb_pmsm_drive_supervisor.sv
// self-checking bench for the drive supervisor
`timescale 1ns/1ps
module tb_pmsm_drive_supervisor;
  import pmsm_pkg::*;
  localparam int CC = 64;
  logic clk = 0, rstn = 0, sw = 1, rst_ev = 0, hw_n = 1, enc_a, enc_b, align, vec, ccw;
  logic [11:0] cmd = 12'h800, vbus = 12'h300, iu = 12'h800, iw = 12'h800, vdv;
  logic signed [15:0] vcmd = 16'h0000, pos, iu_ma, iw_ma;
  logic signed [31:0] pref;
  logic pdone;
  logic [7:0] quarter = 8'h00;
  logic [2:0] pwm_out, pwm_oe;
  logic [4:0] flags;
  logic [10:0] spd;
  logic [23:0] per;
  sys_mode_t mode;
  run_mode_t run;
  int errors = 0, check_count = 0, hi;
  always #4 clk = ~clk;
  pmsm_encoder_model enc_u (.clk(clk), .quarter(quarter), .enc_a(enc_a), .enc_b(enc_b));
  pmsm_drive_supervisor #(.CHECK_CYCLES(CC), .MIN_ENC_PERIOD(40), .ENC_W(24)) dut_u (
    .clk(clk), .rstn(rstn), .start_stop_switch(sw), .reset_event(rst_ev), .hw_overcurrent_n(hw_n),
    .command_adc_channel(cmd), .bus_voltage_adc_channel(vbus), .u_current_adc_channel(iu),
    .w_current_adc_channel(iw), .volt_cmd_u(vcmd), .volt_cmd_v(vcmd), .volt_cmd_w(vcmd),
    .enc_a(enc_a), .enc_b(enc_b), .target_angle_input(16'h0000), .acceleration_time_input(16'h0000),
    .profile_max_speed_input(16'h0000), .settle_wait_input(16'h0000), .pwm_out(pwm_out), .pwm_oe(pwm_oe),
    .system_mode(mode), .run_mode(run), .d_axis_align(align), .vector_control_en(vec), .fault_flags(flags),
    .position_cmd_ddeg(pos), .speed_cmd_rpm(spd), .speed_cmd_ccw(ccw), .bus_voltage_dv(vdv),
    .u_current_ma(iu_ma), .w_current_ma(iw_ma), .enc_period(per), .position_ref(pref), .profile_done(pdone));
  task check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task wait_mode(input sys_mode_t m);
    int k;
    k = 0;
    while (mode !== m && k < 4 * CC)
    begin
      tick(1);
      k++;
    end
    #1;
    check(32'(mode), 32'(m));
  endtask
  task scale(input logic [11:0] c, input logic [15:0] p, input logic [10:0] s, input logic d);
    @(posedge clk) cmd <= c;
    tick(2);
    check({16'h0000, pos}, 32'(p));
    check(32'(spd), 32'(s));
    check(32'(ccw), 32'(d));
  endtask
  // divider refreshes every other valley, so allow several carrier periods to settle
  task duty(input logic signed [15:0] v, input int lo, input int up);
    @(posedge clk) vcmd <= v;
    tick(6 * CC);
    hi = 0;
    repeat (CC)
    begin
      @(posedge clk);
      #1;
      hi += pwm_out[0] + pwm_out[1] + pwm_out[2];
    end
    check(32'(hi >= lo && hi <= up), 32'h1);
  endtask
  // over selects the first tripping code (over-speed uses quarter 5, period 20, where quarter 9 would already trip), otherwise the last code that must not trip
  task stim(input int b, input logic over);
    case (b)
      0: hw_n <= ~over;
      1: iu <= over ? 12'hB0F : 12'hB0E;
      2: vbus <= over ? 12'h409 : 12'h408;
      3: vbus <= over ? 12'h204 : 12'h205;
      default: quarter <= over ? 8'h05 : 8'h0A;
    endcase
  endtask
  task fault(input int b);
    @(posedge clk) sw <= 0;
    wait_mode(SYS_DRIVING);
    @(posedge clk) stim(b, 0);
    tick(3 * CC);
    check(32'(mode), 32'(SYS_DRIVING));
    if (b == 4) check(32'(per), 32'h28);
    @(posedge clk) stim(b, 1);
    tick(1);
    if (b == 0) check(32'(pwm_oe), 32'h0);
    wait_mode(SYS_ERROR);
    check(32'(pwm_oe), 32'h0);
    check(32'(flags[b]), 32'h1);
    // over-speed runs last: a stalled channel keeps its short period for a long time
    if (b == 4) return;
    @(posedge clk)
    begin
      sw <= 1;
      hw_n <= 1;
      iu <= 12'h800;
      vbus <= 12'h300;
    end
    tick(2);
    check(32'(mode), 32'(SYS_ERROR));
    @(posedge clk) rst_ev <= 1;
    @(posedge clk) rst_ev <= 0;
    wait_mode(SYS_STOPPED);
    check(32'(flags), 32'h0);
  endtask
  task summarize;
    $display("errors=%0d checks=%0d", errors, check_count);
    if (errors == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    #(8 * 60000);
    errors++;
    summarize();
  end
  initial
  begin
    repeat (6) @(posedge clk);
    rstn <= 1;
    tick(2);
    check(32'(mode), 32'(SYS_STOPPED));
    check(32'(pwm_oe), 32'h0);
    scale(12'hFFF, 16'h0707, 11'h7CF, 1'b0);
    scale(12'h000, 16'hF8F8, 11'h7D0, 1'b1);
    scale(12'h800, 16'h0000, 11'h000, 1'b0);
    @(posedge clk)
    begin
      iu <= 12'hABC;
      iw <= 12'h544;
    end
    tick(2);
    check(32'(iu_ma), 32'h0D5A);
    check({16'h0000, iw_ma}, 32'hF2A6);
    check(32'(vdv), 32'h0D0);
    @(posedge clk)
    begin
      iu <= 12'h800;
      iw <= 12'h800;
      sw <= 0;
    end
    tick(2);
    check(32'(mode), 32'(SYS_DRIVING));
    tick(4);
    check(32'(run), 32'(RUN_INIT));
    check(32'(align), 32'h1);
    check(32'(vec), 32'h0);
    check(32'(pwm_oe), 32'h7);
    check(pref, 32'h0);
    check(32'(pdone), 32'h0);
    duty(16'sh0000, 72, 120);
    duty(16'sh0180, 132, 156);
    @(posedge clk) sw <= 1;
    tick(2);
    check(32'(mode), 32'(SYS_STOPPED));
    tick(2);
    check(32'(run), 32'(RUN_IDLE));
    check(32'(pwm_oe), 32'h0);
    for (int b = 0; b < 5; b++)
      fault(b);
    summarize();
  end
endmodule
